// >>> ttai_pkg.sv
`default_nettype none
package ttai_pkg;

  // ----------------------------------------
  // widths and channel numbering
  // ----------------------------------------
  localparam int CNT_W = 12;
  localparam int CODE_W = 3;
  localparam int NUM_CH = 3;
  localparam int CH_LOCAL = 0;
  localparam int CH_REMOTE1 = 1;
  localparam int CH_REMOTE2 = 2;
  localparam int ADR_W = 10;
  localparam int IDX_W = 8;

  // ----------------------------------------
  // interval timing, in monitoring cycles
  // ----------------------------------------
  localparam logic [CNT_W-1:0] DEC_BASE_CYCLES = 12'h008;
  localparam logic [CNT_W-1:0] SAT_CYCLES = 12'h800;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

  // ----------------------------------------
  // register indices (byte address is index times four)
  // ----------------------------------------
  localparam logic [IDX_W-1:0] IDX_R2_MSB = 8'h36;
  localparam logic [IDX_W-1:0] IDX_INTERVAL = 8'h37;
  localparam logic [IDX_W-1:0] IDX_CONFIG = 8'h40;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h42;
  localparam logic [IDX_W-1:0] IDX_ELAPSED_BASE = 8'h44;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int R1_LSB = 0;
  localparam int LOCAL_LSB = 3;
  localparam int R2_LO_LSB = 6;
  localparam int R2_MSB_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int STAT_INC_LSB = 3;
  localparam logic [7:0] INTERVAL_RST = 8'h00;
  localparam logic R2_MSB_RST = 1'b0;
  localparam logic LOCK_RST = 1'b0;

  // ----------------------------------------
  // bus slave states
  // ----------------------------------------
  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } ttai_wb_state_type;

  // decrease interval: base doubled once per code step
  function automatic logic [CNT_W-1:0] ttai_dec_interval(input logic [CODE_W-1:0] code);
    return DEC_BASE_CYCLES << code;
  endfunction

  // increase interval: always twice the decrease interval
  function automatic logic [CNT_W-1:0] ttai_inc_interval(input logic [CODE_W-1:0] code);
    return ttai_dec_interval(code) << 1;
  endfunction

endpackage
`default_nettype wire

// >>> ttai_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// control side to one channel interval timer
// ----------------------------------------
interface ttai_chan_if #(
  parameter int CNT_W = ttai_pkg::CNT_W
);
  logic [ttai_pkg::CODE_W-1:0] code;
  logic ce;
  logic mon_tick;
  logic dec_req;
  logic inc_req;
  logic dec_ok;
  logic inc_ok;
  logic dec_grant;
  logic inc_grant;
  logic [CNT_W-1:0] elapsed;

  modport ctrl (
    output code, ce, mon_tick, dec_req, inc_req,
    input dec_ok, inc_ok, dec_grant, inc_grant, elapsed
  );

  modport timer (
    input code, ce, mon_tick, dec_req, inc_req,
    output dec_ok, inc_ok, dec_grant, inc_grant, elapsed
  );
endinterface
`default_nettype wire

// >>> ttai_chan_timer.sv
`timescale 1ns/100ps
`default_nettype none
module ttai_chan_timer #(
  parameter int CNT_W = ttai_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ttai_chan_if.timer ch
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] elapsed;
    logic dec_ok;
    logic inc_ok;
    logic dec_grant;
    logic inc_grant;
  } ttai_timer_state_type;

  ttai_timer_state_type st;
  ttai_timer_state_type next_st;
  logic [CNT_W-1:0] dec_lim;
  logic [CNT_W-1:0] inc_lim;

  // interval limits follow the live code
  assign dec_lim = CNT_W'(ttai_pkg::ttai_dec_interval(ch.code));
  assign inc_lim = CNT_W'(ttai_pkg::ttai_inc_interval(ch.code));

  // ----------------------------------------
  // count monitoring cycles, grant when interval has passed
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.dec_grant = 1'b0;
    next_st.inc_grant = 1'b0;
    // counts monitoring cycles, not clocks; saturates so it never wraps
    if (ch.mon_tick && st.elapsed != CNT_W'(ttai_pkg::SAT_CYCLES))
    begin
      next_st.elapsed = st.elapsed + CNT_W'(ttai_pkg::CNT_ONE);
    end
    // decrease wins a tie; the counter restarts from the granted step
    if (ch.dec_req && st.elapsed >= dec_lim)
    begin
      next_st.dec_grant = 1'b1;
      next_st.elapsed = CNT_W'(ttai_pkg::CNT_ZERO);
    end
    else if (ch.inc_req && st.elapsed >= inc_lim)
    begin
      next_st.inc_grant = 1'b1;
      next_st.elapsed = CNT_W'(ttai_pkg::CNT_ZERO);
    end
    next_st.dec_ok = next_st.elapsed >= dec_lim;
    next_st.inc_ok = next_st.elapsed >= inc_lim;
  end

  // register the state; clock enable freezes everything
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else if (ch.ce)
    begin
      st <= next_st;
    end
  end

  assign ch.elapsed = st.elapsed;
  assign ch.dec_ok = st.dec_ok;
  assign ch.inc_ok = st.inc_ok;
  assign ch.dec_grant = st.dec_grant;
  assign ch.inc_grant = st.inc_grant;

endmodule // ttai_chan_timer
`default_nettype wire

// >>> ttai_top.sv
// How it works
// - local interval code is read/write, bits 5..3 of the interval register
// - local code sets spacing between threshold adjustments in monitoring cycles
// - decrease interval is 8 cycles at code 000, doubling to 1024 at 111
// - increase interval is double: 16 cycles up to 2048 cycles
// - bits 7..6 hold remote 2 code low bits; its top bit sits in 0x36
// - combined remote 2 code spaces adjustments on the remote 2 channel
// - remote 2 code uses the same doubling map as the local code
// - remote 1 code in bits 2..0, same doubling map
// - once the lock bit is set, the interval register ignores writes
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ttai_top #(
  parameter int CNT_W = ttai_pkg::CNT_W,
  parameter int ADR_W = ttai_pkg::ADR_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // monitoring-cycle strobe and adjustment handshake
  input wire logic mon_tick_i,
  input wire logic [ttai_pkg::NUM_CH-1:0] dec_req_i,
  input wire logic [ttai_pkg::NUM_CH-1:0] inc_req_i,
  output logic [ttai_pkg::NUM_CH-1:0] dec_grant_o,
  output logic [ttai_pkg::NUM_CH-1:0] inc_grant_o,
  output logic [ttai_pkg::NUM_CH-1:0] dec_ok_o,
  output logic [ttai_pkg::NUM_CH-1:0] inc_ok_o,
  output logic lock_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    ttai_pkg::ttai_wb_state_type wb_state;
    logic ack;
    logic [31:0] dat;
    logic [7:0] interval;
    logic r2_msb;
    logic lock;
  } ttai_top_state_type;

  ttai_top_state_type st;
  ttai_top_state_type next_st;

  logic [ttai_pkg::NUM_CH-1:0][ttai_pkg::CODE_W-1:0] chan_code;
  logic [ttai_pkg::NUM_CH-1:0][CNT_W-1:0] elapsed_w;
  logic [ttai_pkg::NUM_CH-1:0] dec_ok_w;
  logic [ttai_pkg::NUM_CH-1:0] inc_ok_w;
  logic [ttai_pkg::NUM_CH-1:0] dec_grant_w;
  logic [ttai_pkg::NUM_CH-1:0] inc_grant_w;
  logic [ttai_pkg::IDX_W-1:0] bus_idx;
  logic wr_lane0;

  // word index of the access; byte address is index times four
  assign bus_idx = wb_adr_i[ADR_W-1:2];
  // registers are eight bits wide, so only lane 0 writes
  assign wr_lane0 = wb_we_i && wb_sel_i[0];

  // ----------------------------------------
  // field decoding
  // ----------------------------------------

  // slice one 3-bit code out of the interval register
  function automatic logic [ttai_pkg::CODE_W-1:0] code_at(input logic [7:0] r, input int lsb);
    return ttai_pkg::CODE_W'(r >> lsb);
  endfunction

  // map codes to channels
  always_comb
  begin
    chan_code[ttai_pkg::CH_LOCAL] = code_at(st.interval, ttai_pkg::LOCAL_LSB);
    chan_code[ttai_pkg::CH_REMOTE1] = code_at(st.interval, ttai_pkg::R1_LSB);
    // remote 2 code is split: top bit lives in a separate register
    chan_code[ttai_pkg::CH_REMOTE2] = {st.r2_msb,
      st.interval[ttai_pkg::R2_LO_LSB +: 2]};
  end

  // ----------------------------------------
  // per-channel interval timers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < ttai_pkg::NUM_CH; g++)
    begin : g_ch
      ttai_chan_if #(.CNT_W(CNT_W)) ch();

      // every channel, remote 2 included, shares the same map
      assign ch.code = chan_code[g];
      assign ch.ce = ce_i;
      assign ch.mon_tick = mon_tick_i;
      assign ch.dec_req = dec_req_i[g];
      assign ch.inc_req = inc_req_i[g];
      assign elapsed_w[g] = ch.elapsed;
      assign dec_ok_w[g] = ch.dec_ok;
      assign inc_ok_w[g] = ch.inc_ok;
      assign dec_grant_w[g] = ch.dec_grant;
      assign inc_grant_w[g] = ch.inc_grant;

      ttai_chan_timer #(
        .CNT_W(CNT_W)
      ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ch(ch)
      );
    end
  endgenerate

  // ----------------------------------------
  // register bus: read mux, writes, acknowledge
  // ----------------------------------------

  // one-cycle ack; ack drops the cycle after it is given
  always_comb
  begin
    logic [31:0] rd;
    rd = '0;
    next_st = st;
    next_st.ack = 1'b0;
    // read data: unmapped indices read as zero and still acknowledge
    case (bus_idx)
      ttai_pkg::IDX_R2_MSB:
      begin
        rd[ttai_pkg::R2_MSB_BIT] = st.r2_msb;
      end
      ttai_pkg::IDX_INTERVAL:
      begin
        rd[7:0] = st.interval;
      end
      ttai_pkg::IDX_CONFIG:
      begin
        rd[ttai_pkg::LOCK_BIT] = st.lock;
      end
      ttai_pkg::IDX_STATUS:
      begin
        rd[ttai_pkg::NUM_CH-1:0] = dec_ok_w;
        rd[ttai_pkg::STAT_INC_LSB +: ttai_pkg::NUM_CH] = inc_ok_w;
      end
      default:
      begin
        rd = '0;
      end
    endcase
    // elapsed counters, one word per channel
    for (int i = 0; i < ttai_pkg::NUM_CH; i++)
    begin
      if (bus_idx == ttai_pkg::IDX_ELAPSED_BASE + ttai_pkg::IDX_W'(i))
      begin
        rd = 32'(elapsed_w[i]);
      end
    end
    case (st.wb_state)
      ttai_pkg::WB_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          next_st.ack = 1'b1;
          next_st.dat = rd;
          next_st.wb_state = ttai_pkg::WB_ACK;
          if (wr_lane0)
          begin
            // locked registers quietly keep their contents
            if (bus_idx == ttai_pkg::IDX_INTERVAL && !st.lock)
            begin
              next_st.interval = wb_dat_i[7:0];
            end
            if (bus_idx == ttai_pkg::IDX_R2_MSB && !st.lock)
            begin
              next_st.r2_msb = wb_dat_i[ttai_pkg::R2_MSB_BIT];
            end
            // write-once: software can set the lock but never clear it
            if (bus_idx == ttai_pkg::IDX_CONFIG)
            begin
              next_st.lock = st.lock | wb_dat_i[ttai_pkg::LOCK_BIT];
            end
          end
        end
      end
      ttai_pkg::WB_ACK:
      begin
        // master releases the request after seeing ack
        next_st.wb_state = ttai_pkg::WB_IDLE;
      end
      default:
      begin
        next_st.wb_state = ttai_pkg::WB_IDLE;
      end
    endcase
  end

  // register the state; clock enable freezes everything
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st.wb_state <= ttai_pkg::WB_IDLE;
      st.ack <= 1'b0;
      st.dat <= '0;
      st.interval <= ttai_pkg::INTERVAL_RST;
      st.r2_msb <= ttai_pkg::R2_MSB_RST;
      st.lock <= ttai_pkg::LOCK_RST;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign lock_o = st.lock;
  assign dec_grant_o = dec_grant_w;
  assign inc_grant_o = inc_grant_w;
  assign dec_ok_o = dec_ok_w;
  assign inc_ok_o = inc_ok_w;

endmodule // ttai_top
`default_nettype wire

// >>> ttai_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ttai_top_check (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [2:0] dec_req_i,
  input wire logic [2:0] inc_req_i,
  input wire logic [2:0] dec_grant_o,
  input wire logic [2:0] inc_grant_o,
  input wire logic [2:0] dec_ok_o,
  input wire logic [2:0] inc_ok_o,
  input wire logic lock_o
);
  // ----------------------------------------
  // bus and adjustment checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_grant_req: assert property (((dec_grant_o & ~$past(dec_req_i))
    | (inc_grant_o & ~$past(inc_req_i))) == 3'h0)
    else $error("grant without request");
  a_dec_wins: assert property ((inc_grant_o & $past(dec_req_i & dec_ok_o)) == 3'h0)
    else $error("increase granted over decrease");
  a_grant_gap: assert property (((dec_grant_o | inc_grant_o)
    & $past(dec_grant_o | inc_grant_o)) == 3'h0)
    else $error("grants on back-to-back cycles");
  a_ok_drops: assert property (((dec_grant_o | inc_grant_o)
    & (dec_ok_o | inc_ok_o)) == 3'h0)
    else $error("ok still high with grant");
  a_inc_after_dec: assert property ((inc_ok_o & ~dec_ok_o) == 3'h0)
    else $error("increase ok before decrease ok");
  a_lock_sticky: assert property (lock_o |=> lock_o)
    else $error("lock cleared");
  a_lock_cause: assert property ($rose(lock_o)
    |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_dat_i[1]))
    else $error("lock set without write");
endmodule // ttai_top_check

bind ttai_top ttai_top_check u_chk (.*);
`default_nettype wire

// >>> test_ttai_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_ttai_top;
  // ----------------------------------------
  // stimulus and model state
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic mt = 1'b0;
  logic ce = 1'b1;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [2:0] dreq = 3'h0;
  logic [2:0] ireq = 3'h0;
  logic [2:0] code [3];
  logic lk = 1'b0;
  wire logic [31:0] dat_o;
  wire logic ack;
  wire logic lock;
  wire logic [2:0] dg, ig, dok, iok;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 66;
  int cycles = 0;
  int el [3];

  ttai_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .mon_tick_i(mt), .dec_req_i(dreq), .inc_req_i(ireq),
    .dec_grant_o(dg), .inc_grant_o(ig), .dec_ok_o(dok), .inc_ok_o(iok), .lock_o(lock)
  );

  // 25 ns clock
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  // hang guard: a full run takes about 31k cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 45000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; waits for ack however long it takes
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    bus(1'b0, idx, 8'h00);
    chk(nm, rdat, exp);
  endtask

  // base of eight cycles, doubled per code step, doubled again for increases
  function automatic int ivl(input logic [2:0] c, input logic inc);
    return 8 << c << inc;
  endfunction

  // program all three codes; model keeps old codes once locked
  task automatic setc(input logic [2:0] c0, input logic [2:0] c1, input logic [2:0] c2);
    bus(1'b1, 8'h37, {c2[1:0], c0, c1});
    bus(1'b1, 8'h36, {7'h00, c2[2]});
    if (!lk)
    begin
      code[0] = c0;
      code[1] = c1;
      code[2] = c2;
    end
    rd(8'h37, {24'h000000, code[2][1:0], code[0], code[1]}, "interval");
    rd(8'h36, {31'h00000000, code[2][2]}, "r2_msb");
  endtask

  // one monitoring tick, then a one-cycle request burst
  task automatic step(input logic [2:0] rm, input logic [2:0] im);
    logic [2:0] xd;
    logic [2:0] xi;
    logic [2:0] gd;
    @(posedge clk_i);
    mt <= 1'b1;
    @(posedge clk_i);
    mt <= 1'b0;
    @(posedge clk_i);
    #1;
    for (int c = 0; c < 3; c++)
    begin
      el[c] = (el[c] < 2048) ? el[c] + 1 : 2048;
      xd[c] = el[c] >= ivl(code[c], 1'b0);
      xi[c] = el[c] >= ivl(code[c], 1'b1);
    end
    chk("dec_ok", 32'(dok), 32'(xd));
    chk("inc_ok", 32'(iok), 32'(xi));
    @(posedge clk_i);
    dreq <= rm;
    ireq <= im;
    @(posedge clk_i);
    dreq <= 3'h0;
    ireq <= 3'h0;
    #1;
    gd = rm & xd;
    chk("dec_grant", 32'(dg), 32'(gd));
    chk("inc_grant", 32'(ig), 32'(im & xi & ~gd));
    for (int c = 0; c < 3; c++)
      if (gd[c] || (im[c] && xi[c])) el[c] = 0;
  endtask

  // main sequence
  initial
  begin
    for (int c = 0; c < 3; c++)
    begin
      el[c] = 0;
      code[c] = 3'h0;
    end
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h37, 32'h00000000, "interval_rst");
    rd(8'h36, 32'h00000000, "r2_msb_rst");
    bus(1'b1, 8'h20, 8'hFF);
    rd(8'h20, 32'h00000000, "unmapped");
    for (int r = 0; r < 8; r++)
    begin
      setc(3'(r), 3'($random(seed)), 3'(7 - r));
      repeat (ivl(3'(r), 1'b1) + 4)
        step(3'($random(seed) & $random(seed) & $random(seed)),
          3'($random(seed) & $random(seed) & $random(seed)));
    end
    // top code on all channels, counters run into saturation
    setc(3'h7, 3'h7, 3'h7);
    repeat (2050) step(3'h0, 3'h0);
    for (int c = 0; c < 3; c++)
      rd(8'h44 + 8'(c), 32'h00000800, "elapsed");
    rd(8'h42, 32'h0000003F, "status");
    step(3'h7, 3'h7);
    bus(1'b1, 8'h40, 8'h02);
    lk = 1'b1;
    chk("lock", 32'(lock), 32'h00000001);
    setc(3'h2, 3'h5, 3'h6);
    bus(1'b1, 8'h40, 8'h00);
    chk("lock_hold", 32'(lock), 32'h00000001);
    // clock enable low: a monitoring tick must not be counted
    @(posedge clk_i);
    ce <= 1'b0;
    mt <= 1'b1;
    @(posedge clk_i);
    mt <= 1'b0;
    @(posedge clk_i);
    ce <= 1'b1;
    rd(8'h44, 32'h00000000, "elapsed_frozen");
    close_out();
  end
endmodule // test_ttai_top
`default_nettype wire
